/* core/mft_counter.sv */
// Purpose: One down-counter with write, preset and reload
// Assumes: Controls come from the same clock domain
// Notes:   Bus write beats preset, preset beats counting
`timescale 1ns/100ps
`default_nettype none
module mft_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Counter bundle
  mft_cnt_if.cnt    p
);
  assign p.underflow = p.tick & (p.count == {W{1'b0}}) & ~p.wr & ~p.preset;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      p.count <= {W{1'b0}};
    end else if (p.wr) begin
      p.count <= p.wr_val;
    end else if (p.preset) begin
      p.count <= {W{1'b1}};
    end else if (p.underflow) begin
      p.count <= p.reload_val;
    end else if (p.tick) begin
      p.count <= p.count - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

/* core/mft_sync.sv */
// Purpose: Two-flop synchroniser for one pin
// Assumes: Pin is asynchronous to sys_clk
// Notes:   Only the second flop is visible
`timescale 1ns/100ps
`default_nettype none
module mft_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Pin and result
  input  wire logic pin,
  output var  logic pin_sync
);
  logic meta;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta     <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta     <= pin;
      pin_sync <= meta;
    end
  end
endmodule
`default_nettype wire

/* core/mft_top.sv */
// Purpose: Dual 16-bit timer with reload, capture and toggle pin
// Assumes: AHB-Lite slave, zero wait states, single clock sys_clk
// Notes:   timer_irq1 feeds IRQ14, timer_irq2 feeds IRQ13
`timescale 1ns/100ps
`default_nettype none
module mft_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // Timer pins
  input  wire logic        toggle_pin_in,
  output var  logic        toggle_pin_out,
  output var  logic        toggle_pin_oe,
  input  wire logic        capture_event_pin,
  // System interrupts
  output var  logic        timer_irq1,
  output var  logic        timer_irq2
);
  import mft_pkg::*;

  //--------------------------------------------------------------------
  // Registers and bundles
  //--------------------------------------------------------------------
  logic [6:0]         mctl;
  logic [3:0]         ckc;
  logic [4:0]         prsc;
  logic [4:0]         ps_cnt;
  logic [TIMER_W-1:0] cra;
  logic [TIMER_W-1:0] crb;
  logic [3:0]         irq_en;
  logic [3:0]         irq_pend;
  logic               wr_act;
  logic [7:0]         wr_idx;
  logic               sel_b;
  logic               ta_level;
  logic               prev_ta;
  logic               prev_tb;
  logic               ta_s;
  logic               tb_s;

  mft_cnt_if #(.W(TIMER_W)) c1 ();
  mft_cnt_if #(.W(TIMER_W)) c2 ();

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  wire        addr_ok = hsel & htrans[1] & hready;
  wire [7:0]  acc_idx = haddr[9:2];
  wire        wr_cnt1 = wr_act & (wr_idx == IDX_CNT1);
  wire        wr_cra  = wr_act & (wr_idx == IDX_CRA);
  wire        wr_crb  = wr_act & (wr_idx == IDX_CRB);
  wire        wr_cnt2 = wr_act & (wr_idx == IDX_CNT2);
  wire        wr_prsc = wr_act & (wr_idx == IDX_PRSC);
  wire        wr_ckc  = wr_act & (wr_idx == IDX_CKC);
  wire        wr_mctl = wr_act & (wr_idx == IDX_MCTL);
  wire        wr_ictl = wr_act & (wr_idx == IDX_ICTL);
  wire        wr_iclr = wr_act & (wr_idx == IDX_ICLR);
  wire [31:0] rd_word =
    (acc_idx == IDX_CNT1) ? {16'h0000, c1.count} :
    (acc_idx == IDX_CRA)  ? {16'h0000, cra} :
    (acc_idx == IDX_CRB)  ? {16'h0000, crb} :
    (acc_idx == IDX_CNT2) ? {16'h0000, c2.count} :
    (acc_idx == IDX_PRSC) ? {27'h0000000, prsc} :
    (acc_idx == IDX_CKC)  ? {28'h0000000, ckc} :
    (acc_idx == IDX_MCTL) ? {25'h0000000, mctl} :
    (acc_idx == IDX_ICTL) ? {24'h000000, irq_pend, irq_en} :
    32'h00000000;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_act    <= 1'b0;
      wr_idx    <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_act    <= addr_ok & hwrite;
      wr_idx    <= acc_idx;
      hrdata    <= (addr_ok & ~hwrite) ? rd_word : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Mode and clock selection
  //--------------------------------------------------------------------
  wire mft_mode_t mode   = mft_mode_t'(mctl[MC_MODE_LSB +: 2]);
  wire mft_clk_t  c1_sel = mft_clk_t'(ckc[CKC_C1_LSB +: 2]);
  wire mft_clk_t  c2_sel = mft_clk_t'(ckc[CKC_C2_LSB +: 2]);
  wire toe      = mctl[MC_TOE];
  wire cpe      = mctl[MC_CPE];
  wire til      = mctl[MC_TIL];
  wire tbpol    = mctl[MC_TBPOL];
  wire tapol    = mctl[MC_TAPOL];
  wire cap_mode = (mode == MFT_MODE_DCAP) | (mode == MFT_MODE_SCAP);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mctl <= RST_MCTL;
      ckc  <= RST_CKC;
      prsc <= RST_PRSC;
    end else begin
      if (wr_mctl) mctl <= hwdata[6:0];
      if (wr_ckc)  ckc  <= hwdata[3:0];
      if (wr_prsc) prsc <= hwdata[4:0];
    end
  end

  //--------------------------------------------------------------------
  // Pin sampling and edges
  //--------------------------------------------------------------------
  mft_sync u_sync_ta (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .pin      (toggle_pin_in),
    .pin_sync (ta_s)
  );
  mft_sync u_sync_tb (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .pin      (capture_event_pin),
    .pin_sync (tb_s)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_ta <= 1'b0;
      prev_tb <= 1'b0;
    end else begin
      prev_ta <= ta_s;
      prev_tb <= tb_s;
    end
  end

  // Polarity bit high selects rising edges
  wire ta_edge = tapol ? (ta_s & ~prev_ta) : (~ta_s & prev_ta);
  wire tb_edge = tbpol ? (tb_s & ~prev_tb) : (~tb_s & prev_tb);
  wire tb_act  = (tb_s == tbpol);

  //--------------------------------------------------------------------
  // Prescaler and counter clocks
  //--------------------------------------------------------------------
  wire ps_tick = (ps_cnt == prsc);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ps_cnt <= RST_PRSC;
    end else begin
      ps_cnt <= ps_tick ? RST_PRSC : ps_cnt + 5'h01;
    end
  end

  // Event and accumulate clocks are dead in capture modes
  wire c1_tick = (c1_sel == MFT_CK_PRESC) ? ps_tick :
                 (c1_sel == MFT_CK_EXT)   ? tb_edge & ~cap_mode :
                 (c1_sel == MFT_CK_PACC)  ? ps_tick & tb_act & ~cap_mode :
                 1'b0;
  wire c2_tick = (c2_sel == MFT_CK_PRESC) ? ps_tick :
                 (c2_sel == MFT_CK_EXT)   ? tb_edge & ~cap_mode :
                 (c2_sel == MFT_CK_PACC)  ? ps_tick & tb_act & ~cap_mode :
                 1'b0;

  //--------------------------------------------------------------------
  // Captures and counters
  //--------------------------------------------------------------------
  wire ta_cap  = (mode == MFT_MODE_DCAP) & ta_edge;
  wire tb_cap1 = (mode == MFT_MODE_DCAP) & tb_edge;
  wire tb_cap2 = (mode == MFT_MODE_SCAP) & tb_edge;

  assign c1.tick       = c1_tick;
  assign c1.wr         = wr_cnt1;
  assign c1.wr_val     = hwdata[15:0];
  assign c1.preset     = (ta_cap & toe) | (tb_cap1 & cpe);
  assign c1.reload_val = (mode == MFT_MODE_PWM)  ? (sel_b ? crb : cra) :
                         (mode == MFT_MODE_DCAP) ? PRESET_VAL :
                         cra;
  assign c2.tick       = c2_tick;
  assign c2.wr         = wr_cnt2;
  assign c2.wr_val     = hwdata[15:0];
  assign c2.preset     = tb_cap2 & cpe;
  assign c2.reload_val = (mode == MFT_MODE_SCAP) ? PRESET_VAL : crb;

  mft_counter #(.W(TIMER_W)) u_cnt1 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .p       (c1)
  );
  mft_counter #(.W(TIMER_W)) u_cnt2 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .p       (c2)
  );

  // Capture stores the pre-preset count and beats a bus write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cra <= RST_TIMER;
      crb <= RST_TIMER;
    end else begin
      if (ta_cap)      cra <= c1.count;
      else if (wr_cra) cra <= hwdata[15:0];
      if (tb_cap1)      crb <= c1.count;
      else if (tb_cap2) crb <= c2.count;
      else if (wr_crb)  crb <= hwdata[15:0];
    end
  end

  // Alternate reload source, restarts from A whenever stopped
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_b <= 1'b0;
    end else if (mode != MFT_MODE_PWM || c1_sel == MFT_CK_STOP) begin
      sel_b <= 1'b0;
    end else if (c1.underflow) begin
      sel_b <= ~sel_b;
    end
  end

  //--------------------------------------------------------------------
  // Toggle pin
  //--------------------------------------------------------------------
  wire tog_en  = toe & (mode != MFT_MODE_DCAP);
  wire ta_rise = tog_en & c1.underflow & ~ta_level;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ta_level      <= 1'b0;
      toggle_pin_oe <= 1'b0;
    end else begin
      toggle_pin_oe <= tog_en;
      if (!tog_en || c1_sel == MFT_CK_STOP) begin
        ta_level <= til;
      end else if (c1.underflow) begin
        ta_level <= ~ta_level;
      end
    end
  end
  assign toggle_pin_out = ta_level;

  //--------------------------------------------------------------------
  // Interrupt sources
  //--------------------------------------------------------------------
  wire set_a = (mode == MFT_MODE_PWM)  ? c1.underflow & ~sel_b :
               (mode == MFT_MODE_DCAP) ? ta_cap :
               ta_rise;
  wire set_b = (mode == MFT_MODE_PWM)  ? c1.underflow & sel_b :
               (mode == MFT_MODE_DCAP) ? tb_cap1 :
               (mode == MFT_MODE_SCAP) ? tb_cap2 :
               1'b0;
  wire set_c = (mode == MFT_MODE_DCAP) & c1.underflow;
  wire set_d = c2.underflow;
  wire [3:0] pend_set  = {set_d, set_c, set_b, set_a};
  wire [3:0] clr_mask  = wr_iclr ? hwdata[3:0] : 4'h0;
  // Set beats a clear in the same cycle
  wire [3:0] next_pend = (irq_pend & ~clr_mask) | pend_set;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_en     <= 4'h0;
      irq_pend   <= 4'h0;
      timer_irq1 <= 1'b0;
      timer_irq2 <= 1'b0;
    end else begin
      if (wr_ictl) irq_en <= hwdata[ICTL_EN_LSB +: 4];
      irq_pend   <= next_pend;
      timer_irq1 <= |(irq_pend[2:0] & irq_en[2:0]);
      timer_irq2 <= irq_pend[PND_D] & irq_en[PND_D];
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_c1_wrap;
    c1_tick && c1.count == 16'h0000 && !c1.wr && !c1.preset;
  endsequence
  sequence s_rise;
    (mode == MFT_MODE_DUAL || mode == MFT_MODE_SCAP) && ta_rise;
  endsequence
  sequence s_cap2;
    tb_cap2 && !wr_cnt2;
  endsequence

  AST_C1_RELOAD: assert property (
    (mode == MFT_MODE_DUAL) and s_c1_wrap |=> c1.count == $past(cra))
    else $error("first counter did not reload from A");
  AST_TOGGLE: assert property (
    tog_en && c1_sel != MFT_CK_STOP && c1.underflow
      |=> toggle_pin_out != $past(toggle_pin_out))
    else $error("toggle pin did not invert on underflow");
  AST_TOG_INIT: assert property (
    !tog_en |=> toggle_pin_out == $past(til))
    else $error("toggle pin not at initial level");
  AST_RISE_IRQ: assert property (
    s_rise ##1 irq_en[PND_A] |=> timer_irq1 && irq_pend[PND_A])
    else $error("rising toggle gave no interrupt");
  AST_C2_RELOAD: assert property (
    mode == MFT_MODE_DUAL && c2.underflow |=> c2.count == $past(crb))
    else $error("second counter did not reload from B");
  AST_D_FLAG: assert property (
    c2.underflow |=> irq_pend[PND_D])
    else $error("second underflow did not set D");
  AST_CAPTURE: assert property (
    s_cap2 |=> crb == $past(c2.count)
      && (!$past(cpe) || c2.count == PRESET_VAL) && irq_pend[PND_B])
    else $error("capture or preset wrong");
  AST_STOP: assert property (
    cap_mode && (c1_sel == MFT_CK_EXT || c1_sel == MFT_CK_PACC)
      && !c1.wr && !c1.preset |=> $stable(c1.count))
    else $error("counter ran on a forbidden clock");
  AST_STOP2: assert property (
    cap_mode && (c2_sel == MFT_CK_EXT || c2_sel == MFT_CK_PACC)
      && !c2.wr && !c2.preset |=> $stable(c2.count))
    else $error("second counter ran on a forbidden clock");
  AST_IRQ2: assert property (
    irq_pend[PND_D] && irq_en[PND_D] |=> timer_irq2 ##1 1'b1)
    else $error("interrupt 2 not raised");
  AST_IRQ1_QUIET: assert property (
    !(|(irq_pend[2:0] & irq_en[2:0])) |=> !timer_irq1)
    else $error("interrupt 1 without cause");
  AST_IDLE: assert property (
    mode == MFT_MODE_DUAL |-> !set_b && !set_c)
    else $error("unused source set in mode 3");
  AST_C_FLAG: assert property (
    mode == MFT_MODE_DCAP && c1.underflow |=> irq_pend[PND_C])
    else $error("dual capture underflow did not set C");
  AST_HOLD: assert property (
    irq_pend[PND_A] && !clr_mask[PND_A] |=> irq_pend[PND_A])
    else $error("pending flag dropped without clear");
  AST_NO_TOG: assert property (
    mode == MFT_MODE_DCAP |=> !toggle_pin_oe)
    else $error("toggle output driven in dual capture");
endmodule
`default_nettype wire

/* shared/mft_cnt_if.sv */
// Purpose: Control and status bundle between timer logic and one counter
// Assumes: Single clock domain
// Notes:   ctl side steers, cnt side holds the count
`timescale 1ns/100ps
`default_nettype none
interface mft_cnt_if #(parameter int W = 16);
  logic         tick;
  logic         preset;
  logic         wr;
  logic [W-1:0] wr_val;
  logic [W-1:0] reload_val;
  logic [W-1:0] count;
  logic         underflow;
  modport ctl (output tick, preset, wr, wr_val, reload_val,
               input count, underflow);
  modport cnt (input tick, preset, wr, wr_val, reload_val,
               output count, underflow);
endinterface
`default_nettype wire

/* shared/mft_pkg.sv */
// Purpose: Constants and types shared by the dual timer files
// Assumes: AHB-Lite word access, register index times four is byte address
// Notes:   Behaviour list follows
// Behaviour
// - Mode 3: first counter counts down, underflow reloads reload_capture_a
// - Toggle enabled: toggle pin inverts on each first counter underflow
// - Toggle pin starting level equals toggle_initial_level
// - Modes 3 and 4: rising toggle sets pending flag A, irq if enabled
// - Mode 3: second counter counts down, reloads from reload_capture_b
// - Mode 3: second counter underflow sets pending D, irq if enabled
// - Mode 3: capture/event pin clocks either counter, or prescaled clock
// - Mode 4: capture pin edge copies second counter into reload_capture_b
// - Capture preset: capture first, then preset counter to FFFFh
// - Mode 4: capture sets pending B, second underflow sets pending D
// - Mode 4: event or accumulate clock selection stops that counter
// - Sources A, B, C form timer interrupt 1; D alone timer interrupt 2
// - Timer interrupt 1 is IRQ14, timer interrupt 2 is IRQ13
// - Each source has enable and pending; irq needs both set
// - Unused sources never set: B, C in mode 3; C in mode 4
// - Mode 2: A, B on capture edges, C, D on counter underflows
// - Pin functions follow mode, toggle enable and capture preset enable
// - Toggle output only in modes 1, 3 and 4
`default_nettype none
package mft_pkg;

  localparam int TIMER_W = 16;

  // Register indices, byte address is index times four
  localparam logic [7:0] IDX_CNT1 = 8'h40;
  localparam logic [7:0] IDX_CRA  = 8'h42;
  localparam logic [7:0] IDX_CRB  = 8'h44;
  localparam logic [7:0] IDX_CNT2 = 8'h46;
  localparam logic [7:0] IDX_PRSC = 8'h48;
  localparam logic [7:0] IDX_CKC  = 8'h4A;
  localparam logic [7:0] IDX_MCTL = 8'h4C;
  localparam logic [7:0] IDX_ICTL = 8'h4E;
  localparam logic [7:0] IDX_ICLR = 8'h50;

  // Mode control fields
  localparam int MC_MODE_LSB = 0;
  localparam int MC_TOE      = 2;
  localparam int MC_CPE      = 3;
  localparam int MC_TIL      = 4;
  localparam int MC_TBPOL    = 5;
  localparam int MC_TAPOL    = 6;
  // Clock select fields, two bits each
  localparam int CKC_C1_LSB  = 0;
  localparam int CKC_C2_LSB  = 2;
  // Interrupt control fields and pending bit numbers
  localparam int ICTL_EN_LSB  = 0;
  localparam int ICTL_PND_LSB = 4;
  localparam int PND_A = 0;
  localparam int PND_B = 1;
  localparam int PND_C = 2;
  localparam int PND_D = 3;

  // Values after reset and fixed values
  localparam logic [6:0]  RST_MCTL   = 7'h00;
  localparam logic [3:0]  RST_CKC    = 4'h0;
  localparam logic [4:0]  RST_PRSC   = 5'h00;
  localparam logic [15:0] RST_TIMER  = 16'h0000;
  localparam logic [15:0] PRESET_VAL = 16'hFFFF;

  typedef enum logic [1:0] {
    MFT_MODE_PWM,
    MFT_MODE_DCAP,
    MFT_MODE_DUAL,
    MFT_MODE_SCAP
  } mft_mode_t;

  typedef enum logic [1:0] {
    MFT_CK_STOP,
    MFT_CK_PRESC,
    MFT_CK_EXT,
    MFT_CK_PACC
  } mft_clk_t;

endpackage
`default_nettype wire

/* sim/mft_pin_model.sv */
// Purpose: Far-side model of the toggle and capture/event pins
// Assumes: One sys_clk domain, pin changes just after rising edges
// Notes:   Toggle pin resolves to the device level while it drives
`timescale 1ns/100ps
`default_nettype none
module mft_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Device side of the toggle pin
  input  wire logic tog_out,
  input  wire logic tog_oe,
  // Levels seen by the device
  output var  logic tog_wire,
  output var  logic cap_pin
);
  logic tog_ext;

  initial begin
    tog_ext = 1'b0;
    cap_pin = 1'b0;
  end

  // Released line carries the level the far side drives
  assign tog_wire = tog_oe ? tog_out : tog_ext;

  // Far-side level on the released toggle pin, held whole cycles
  task automatic drive_tog(input logic lvl, input int hold);
    @(posedge sys_clk);
    tog_ext <= lvl;
    repeat (hold) @(posedge sys_clk);
  endtask

  // Each level is held whole cycles, never under one
  task automatic drive(input logic lvl, input int hold);
    @(posedge sys_clk);
    cap_pin <= lvl;
    repeat (hold) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the dual timer
// Assumes: Zero-wait AHB-Lite slave, 200 MHz sys_clk
// Notes:   Reads queue their expected word, a monitor compares
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import mft_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        rd_ph = 1'b0, hreadyout, hresp, timer_irq1, timer_irq2;
  logic        tog_out, tog_oe, tog_wire, cap_pin;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [31:0] exp_q[$];
  logic [15:0] ra, rb, va;
  int          err_total = 0, checks = 0, n;

  mft_top mft_top_i (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .toggle_pin_in(tog_wire), .toggle_pin_out(tog_out),
    .toggle_pin_oe(tog_oe), .capture_event_pin(cap_pin),
    .timer_irq1(timer_irq1), .timer_irq2(timer_irq2)
  );

  mft_pin_model mft_pin_model_i (
    .sys_clk(sys_clk), .tog_out(tog_out), .tog_oe(tog_oe),
    .tog_wire(tog_wire), .cap_pin(cap_pin)
  );

  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rd_ph  <= !wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd_ph  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(idx, 1'b1, wd);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(idx, 1'b0, 32'h0);
  endtask

  // Read data is taken at the edge that ends the data phase
  always @(posedge sys_clk) begin
    if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
    end
  end

  // Cycles until the toggle pin changes level
  task automatic gap(output int g);
    logic l;
    l = tog_out;
    g = 0;
    do begin
      @(posedge sys_clk);
      g++;
    end while (tog_out === l && g < 60);
  endtask

  task automatic pulse();
    mft_pin_model_i.drive(1'b1, 2);
    mft_pin_model_i.drive(1'b0, 3);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h56CD));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk({hresp, hreadyout, tog_oe, timer_irq1, timer_irq2}, 32'h8);
    rd(IDX_MCTL, 32'h0);
    rd(IDX_ICTL, 32'h0);
    wr(8'h10, 32'hFFFF);
    rd(8'h10, 32'h0);
    done("reset");
    // Mode 3 square wave from the first counter
    ra = 16'($urandom_range(9, 2));
    wr(IDX_CRA, {16'h0, ra});
    wr(IDX_CNT1, {16'h0, ra});
    wr(IDX_MCTL, 32'h16);
    repeat (2) @(posedge sys_clk);
    chk({tog_oe, tog_out}, 32'h3);
    wr(IDX_ICTL, 32'h1);
    wr(IDX_CKC, 32'h1);
    gap(n);
    gap(n);
    chk(n, ra + 1);
    gap(n);
    chk(n, ra + 1);
    wr(IDX_CKC, 32'h0);
    rd(IDX_ICTL, 32'h11);
    chk({timer_irq2, timer_irq1}, 32'h1);
    wr(IDX_ICTL, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(timer_irq1, 32'h0);
    wr(IDX_ICLR, 32'hF);
    wr(IDX_ICTL, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(timer_irq1, 32'h0);
    wr(IDX_MCTL, 32'h15);
    repeat (2) @(posedge sys_clk);
    chk(tog_oe, 32'h0);
    done("toggle");
    // Mode 3 with both counters clocked by pin edges
    ra = 16'($urandom_range(16'hFFFF, 2));
    rb = 16'($urandom_range(16'hFFFF, 2));
    wr(IDX_MCTL, 32'h22);
    wr(IDX_ICTL, 32'h8);
    wr(IDX_ICLR, 32'hF);
    wr(IDX_CRA, {16'h0, ra});
    wr(IDX_CRB, {16'h0, rb});
    wr(IDX_CNT1, 32'h1);
    wr(IDX_CNT2, 32'h1);
    wr(IDX_CKC, 32'hA);
    repeat (3) pulse();
    rd(IDX_CNT1, {16'h0, ra - 16'h1});
    rd(IDX_CNT2, {16'h0, rb - 16'h1});
    rd(IDX_ICTL, 32'h88);
    chk({timer_irq2, timer_irq1}, 32'h2);
    done("event");
    // Mode 4 capture while an invalid clock holds the counter
    va = 16'($urandom);
    wr(IDX_MCTL, 32'h23);
    wr(IDX_CKC, 32'hA);
    wr(IDX_ICLR, 32'hF);
    wr(IDX_ICTL, 32'h2);
    wr(IDX_CNT2, {16'h0, va});
    repeat (2) pulse();
    rd(IDX_CNT2, {16'h0, va});
    rd(IDX_CRB, {16'h0, va});
    rd(IDX_ICTL, 32'h22);
    chk(timer_irq1, 32'h1);
    wr(IDX_MCTL, 32'h2B);
    pulse();
    rd(IDX_CRB, {16'h0, va});
    rd(IDX_CNT2, 32'hFFFF);
    wr(IDX_MCTL, 32'h3);
    wr(IDX_CNT2, {16'h0, ~va});
    mft_pin_model_i.drive(1'b1, 6);
    rd(IDX_CRB, {16'h0, va});
    mft_pin_model_i.drive(1'b0, 6);
    rd(IDX_CRB, {16'h0, ~va});
    wr(IDX_ICLR, 32'hF);
    wr(IDX_ICTL, 32'h8);
    wr(IDX_CNT2, 32'h2);
    wr(IDX_CKC, 32'h4);
    repeat (8) @(posedge sys_clk);
    rd(IDX_ICTL, 32'h88);
    chk({timer_irq2, timer_irq1}, 32'h2);
    done("capture");
    // Mode 1 alternate reloads, then mode 2 captures on both pins
    wr(IDX_CKC, 32'h0);
    wr(IDX_ICTL, 32'h0);
    wr(IDX_ICLR, 32'hF);
    wr(IDX_MCTL, 32'h4);
    wr(IDX_CRA, 32'h2);
    wr(IDX_CRB, 32'h5);
    wr(IDX_CNT1, 32'h0);
    wr(IDX_CKC, 32'h1);
    gap(n);
    gap(n);
    chk(n, 32'h3);
    gap(n);
    chk(n, 32'h6);
    wr(IDX_CKC, 32'h0);
    rd(IDX_ICTL, 32'h30);
    wr(IDX_ICLR, 32'hF);
    wr(IDX_MCTL, 32'h61);
    wr(IDX_ICTL, 32'h7);
    wr(IDX_CNT1, 32'h3);
    wr(IDX_CKC, 32'h1);
    mft_pin_model_i.drive_tog(1'b1, 6);
    pulse();
    rd(IDX_ICTL, 32'h77);
    chk({tog_oe, timer_irq1}, 32'h1);
    mft_pin_model_i.drive_tog(1'b0, 2);
    done("modes 1 and 2");
    complete_run();
  end
endmodule
`default_nettype wire
